// File: hw/ext_line_pkg.sv
// constants, field layout and trigger encoding for the external line controller
package ext_line_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_LINES   = 16;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    localparam int TYPE_W      = 3;
    localparam int CNT_W       = 16;
    localparam int NUM_PERIPH  = 5;

    // ****************************************
    // byte offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_LINE_CFG0  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LINE_CFG15 = 8'h3C;
    localparam logic [ADDR_W-1:0] OFF_INT_EN     = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_EDGE_FLAG  = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_EDGE_STAT  = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_SW_SET     = 8'h4C;
    localparam logic [ADDR_W-1:0] OFF_WAKE_CTRL  = 8'h50;
    localparam logic [ADDR_W-1:0] OFF_WAKE_POL   = 8'h54;
    localparam logic [ADDR_W-1:0] OFF_WAKE_FLAG  = 8'h58;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CFG_DB_EN_BIT  = 31;
    localparam int CFG_TYPE_LSB   = 28;
    localparam int CFG_CNT_LSB    = 0;
    localparam int WAKE_IEN_BIT   = 31;

    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [DATA_W-1:0]    RST_WORD  = 32'h0000_0000;
    localparam logic [NUM_LINES-1:0] RST_LINES = 16'h0000;
    localparam logic [CNT_W-1:0]     RST_CNT   = 16'h0000;
    localparam int SYNC_STAGES  = 2;
    localparam int DET_LATENCY  = SYNC_STAGES + 1;

    typedef enum logic [TYPE_W-1:0] {
        TRIG_LOW  = 3'b000,
        TRIG_HIGH = 3'b001,
        TRIG_FALL = 3'b010,
        TRIG_RISE = 3'b011,
        TRIG_BOTH = 3'b100
    } trig_e;

endpackage

// File: hw/line_det_if.sv
// per-line link between the controller and one input detector
`timescale 1ns/1ps
interface line_det_if;
    logic        raw;
    logic        db_en;
    logic [15:0] db_cnt;
    logic        level;
    logic        rise;
    logic        fall;

    modport ctrl (output raw, output db_en, output db_cnt,
                  input level, input rise, input fall);
    modport det  (input raw, input db_en, input db_cnt,
                  output level, output rise, output fall);
endinterface

// File: hw/line_detector.sv
// one line: two-stage synchroniser, debounce filter and edge pulses
`timescale 1ns/1ps
module line_detector (
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    // line link
    line_det_if.det     lane
);

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        filt;
        logic        rise;
        logic        fall;
        logic [15:0] cnt;
    } det_state_s;

    det_state_s state_reg;
    det_state_s state_next;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        // s1 feeds s2 only, keeping metastability out of the filter
        state_next.s1 = lane.raw;
        state_next.s2 = state_reg.s1;
        if (!lane.db_en) begin
            state_next.filt = state_reg.s2;
            state_next.cnt  = ext_line_pkg::RST_CNT;
        end else if (state_reg.s2 == state_reg.filt) begin
            state_next.cnt = ext_line_pkg::RST_CNT;
        end else if ({1'b0, state_reg.cnt} + 17'h0_0001 >= {1'b0, lane.db_cnt}) begin
            // flips after db_cnt clocks of a steady new level, never less than one
            state_next.filt = state_reg.s2;
            state_next.cnt  = ext_line_pkg::RST_CNT;
        end else begin
            state_next.cnt = state_reg.cnt + 16'h0001;
        end
        state_next.rise = state_next.filt & ~state_reg.filt;
        state_next.fall = ~state_next.filt & state_reg.filt;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign lane.level = state_reg.filt;
    assign lane.rise  = state_reg.rise;
    assign lane.fall  = state_reg.fall;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_db_off;
        !lane.db_en [*4];
    endsequence

    property p_sync_path;
        s_db_off |-> (lane.level == $past(lane.raw, 3));
    endproperty
    a_sync_path: assert property (p_sync_path)
        else $error("level does not follow input after three clocks");

    property p_db_hold;
        (lane.db_en && $past(lane.db_en) && state_reg.s2 != state_reg.filt
         && {1'b0, state_reg.cnt} + 17'h0_0001 < {1'b0, lane.db_cnt})
        |=> $stable(lane.level);
    endproperty
    a_db_hold: assert property (p_db_hold)
        else $error("debounce passed a pulse shorter than the count");

    property p_db_flip;
        (lane.db_en && state_reg.s2 != state_reg.filt
         && {1'b0, state_reg.cnt} + 17'h0_0001 >= {1'b0, lane.db_cnt})
        |=> (lane.level == $past(state_reg.s2));
    endproperty
    a_db_flip: assert property (p_db_flip)
        else $error("debounce did not take a level held for the count");

    property p_rise;
        lane.rise |-> (lane.level && !$past(lane.level) && !lane.fall);
    endproperty
    a_rise: assert property (p_rise)
        else $error("rise pulse without a low to high change");

endmodule

// File: hw/ext_line_controller.sv
// sixteen-line external interrupt and wake-up controller with register port
`timescale 1ns/1ps
module ext_line_controller (
    // clock and reset
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESET_IN,
    // register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RDATA_OUT,
    // line inputs, already pin-selected
    input  wire logic [15:0] LINE_IN,
    // wake requests of other peripherals: lvd, wake pin, comparator, usb, rtc
    input  wire logic [4:0]  PERIPH_WAKE_IN,
    // requests
    output logic      [15:0] LINE_IRQ_OUT,
    output logic             EVENT_WAKE_IRQ_OUT,
    output logic             WAKE_CPU_OUT,
    output logic             WAKE_CLK_OUT
);

    localparam int N = ext_line_pkg::NUM_LINES;

    typedef struct packed {
        logic [N-1:0]        db_en;
        logic [N-1:0][2:0]   trig;
        logic [N-1:0][15:0]  db_cnt;
        logic [N-1:0]        int_en;
        logic [N-1:0]        edge_flag;
        logic [N-1:0]        edge_stat;
        logic [N-1:0]        sw_set;
        logic [N-1:0]        wake_en;
        logic                wake_ien;
        logic [N-1:0]        wake_pol;
        logic [N-1:0]        wake_flag;
        logic [31:0]         rdata;
        logic [N-1:0]        irq;
        logic                ev_irq;
        logic                wake;
    } ctl_state_s;

    ctl_state_s state_reg;
    ctl_state_s state_next;

    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] edge_hit;
    logic [N-1:0] level_hit;
    logic [N-1:0] wake_hit;

    // ****************************************
    // trigger decode
    // ****************************************
    function automatic logic is_edge_type(input logic [2:0] t);
        is_edge_type = t[2] | t[1];
    endfunction

    function automatic logic edge_match(input logic [2:0] t, input logic r, input logic f);
        if (t[2]) begin
            edge_match = r | f;
        end else begin
            case (t[1:0])
                2'b10:   edge_match = f;
                2'b11:   edge_match = r;
                default: edge_match = 1'b0;
            endcase
        end
    endfunction

    function automatic logic level_match(input logic [2:0] t, input logic l);
        case (t)
            ext_line_pkg::TRIG_LOW:  level_match = ~l;
            ext_line_pkg::TRIG_HIGH: level_match = l;
            default:                 level_match = 1'b0;
        endcase
    endfunction

    // ****************************************
    // per-line detectors
    // ****************************************
    // pin selection stays in the alternate-function block; one input arrives per line
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_line
            line_det_if lane ();
            assign lane.raw    = LINE_IN[g];
            assign lane.db_en  = state_reg.db_en[g];
            assign lane.db_cnt = state_reg.db_cnt[g];
            assign lvl[g]      = lane.level;
            assign rise[g]     = lane.rise;
            assign fall[g]     = lane.fall;
            line_detector u_det (
                .clk_in (CORE_CLK_IN),
                .rst_in (RESET_IN),
                .lane   (lane.det)
            );
            assign edge_hit[g]  = edge_match(state_reg.trig[g], rise[g], fall[g]);
            assign level_hit[g] = level_match(state_reg.trig[g], lvl[g]);
            // polarity 0 wakes on high, 1 wakes on low
            assign wake_hit[g]  = state_reg.wake_en[g]
                                  & (lvl[g] ^ state_reg.wake_pol[g]);
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic         word_ok;
        logic [3:0]   idx;
        logic [N-1:0] pend;
        logic [N-1:0] edge_clr;
        logic [N-1:0] wake_clr;
        word_ok  = (ADDR_IN[1:0] == 2'b00);
        idx      = ADDR_IN[5:2];
        edge_clr = '0;
        wake_clr = '0;
        pend     = '0;
        state_next = state_reg;
        state_next.rdata = ext_line_pkg::RST_WORD;

        // register writes
        if (WR_IN && word_ok) begin
            if (ADDR_IN <= ext_line_pkg::OFF_LINE_CFG15) begin
                state_next.db_en[idx]  = WDATA_IN[ext_line_pkg::CFG_DB_EN_BIT];
                state_next.trig[idx]   = WDATA_IN[ext_line_pkg::CFG_TYPE_LSB +: 3];
                state_next.db_cnt[idx] = WDATA_IN[ext_line_pkg::CFG_CNT_LSB +: 16];
            end else begin
                case (ADDR_IN)
                    ext_line_pkg::OFF_INT_EN:    state_next.int_en = WDATA_IN[15:0];
                    ext_line_pkg::OFF_EDGE_FLAG: edge_clr = WDATA_IN[15:0];
                    ext_line_pkg::OFF_SW_SET:    state_next.sw_set = WDATA_IN[15:0];
                    ext_line_pkg::OFF_WAKE_CTRL: begin
                        state_next.wake_en  = WDATA_IN[15:0];
                        state_next.wake_ien = WDATA_IN[ext_line_pkg::WAKE_IEN_BIT];
                    end
                    ext_line_pkg::OFF_WAKE_POL:  state_next.wake_pol = WDATA_IN[15:0];
                    ext_line_pkg::OFF_WAKE_FLAG: wake_clr = WDATA_IN[15:0];
                    default: begin
                    end
                endcase
            end
        end

        // sticky flags: a new event in the clearing cycle survives
        // edge flag is set whatever int_en, so software can poll masked lines
        state_next.edge_flag = (state_reg.edge_flag & ~edge_clr)
                               | edge_hit;
        state_next.wake_flag = (state_reg.wake_flag & ~wake_clr) | wake_hit;
        for (int i = 0; i < N; i++) begin
            if (rise[i] | fall[i]) begin
                state_next.edge_stat[i] = rise[i];
            end
        end

        // requests: line irq gated by int_en, event irq by wake_ien and wake_en, wake by wake_en for lines only
        for (int i = 0; i < N; i++) begin
            pend[i] = (is_edge_type(state_reg.trig[i]) ? state_next.edge_flag[i]
                                                       : level_hit[i])
                      | state_reg.sw_set[i];
        end
        state_next.irq    = state_reg.int_en & pend;
        state_next.ev_irq = state_reg.wake_ien
                            & (|(state_next.wake_flag & state_reg.wake_en));
        state_next.wake   = (|wake_hit) | (|PERIPH_WAKE_IN);

        // register reads, data one cycle later
        if (RD_IN && word_ok) begin
            if (ADDR_IN <= ext_line_pkg::OFF_LINE_CFG15) begin
                state_next.rdata[ext_line_pkg::CFG_DB_EN_BIT]       = state_reg.db_en[idx];
                state_next.rdata[ext_line_pkg::CFG_TYPE_LSB +: 3]   = state_reg.trig[idx];
                state_next.rdata[ext_line_pkg::CFG_CNT_LSB +: 16]   = state_reg.db_cnt[idx];
            end else begin
                case (ADDR_IN)
                    ext_line_pkg::OFF_INT_EN:    state_next.rdata[15:0] = state_reg.int_en;
                    ext_line_pkg::OFF_EDGE_FLAG: state_next.rdata[15:0] = state_reg.edge_flag;
                    ext_line_pkg::OFF_EDGE_STAT: state_next.rdata[15:0] = state_reg.edge_stat;
                    ext_line_pkg::OFF_SW_SET:    state_next.rdata[15:0] = state_reg.sw_set;
                    ext_line_pkg::OFF_WAKE_CTRL: begin
                        state_next.rdata[15:0] = state_reg.wake_en;
                        state_next.rdata[ext_line_pkg::WAKE_IEN_BIT] = state_reg.wake_ien;
                    end
                    ext_line_pkg::OFF_WAKE_POL:  state_next.rdata[15:0] = state_reg.wake_pol;
                    ext_line_pkg::OFF_WAKE_FLAG: state_next.rdata[15:0] = state_reg.wake_flag;
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign RDATA_OUT          = state_reg.rdata;
    assign LINE_IRQ_OUT       = state_reg.irq;
    assign EVENT_WAKE_IRQ_OUT = state_reg.ev_irq;
    // cpu and clock unit see the same request, no extra stage between them
    assign WAKE_CPU_OUT       = state_reg.wake;
    assign WAKE_CLK_OUT       = state_reg.wake;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);

    property p_read_enable;
        (RD_IN && ADDR_IN == ext_line_pkg::OFF_INT_EN)
        |=> (RDATA_OUT == {16'h0000, $past(state_reg.int_en)});
    endproperty
    a_read_enable: assert property (p_read_enable)
        else $error("enable register read back wrong");

    property p_mask;
        !state_reg.int_en[0] |=> !LINE_IRQ_OUT[0];
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked line 0 raised a request");

    property p_sw_trig;
        (state_reg.int_en[5] && state_reg.sw_set[5]) |=> LINE_IRQ_OUT[5];
    endproperty
    a_sw_trig: assert property (p_sw_trig)
        else $error("software trigger did not raise line 5");

    property p_low_level;
        (state_reg.int_en[2] && state_reg.trig[2] == ext_line_pkg::TRIG_LOW && !lvl[2])
        |=> LINE_IRQ_OUT[2];
    endproperty
    a_low_level: assert property (p_low_level)
        else $error("low level on line 2 gave no request");

    property p_rise_flag;
        (rise[0] && state_reg.trig[0] == ext_line_pkg::TRIG_RISE) |=> state_reg.edge_flag[0];
    endproperty
    a_rise_flag: assert property (p_rise_flag)
        else $error("rising edge on line 0 not flagged");

    property p_wake_flag;
        wake_hit[3] |=> state_reg.wake_flag[3];
    endproperty
    a_wake_flag: assert property (p_wake_flag)
        else $error("wake event on line 3 lost");

    property p_ev_irq;
        EVENT_WAKE_IRQ_OUT |-> ($past(state_reg.wake_ien) && $past(state_reg.wake_en) != 16'h0000);
    endproperty
    a_ev_irq: assert property (p_ev_irq)
        else $error("event wake interrupt without its enables");

    sequence s_periph_wake;
        PERIPH_WAKE_IN != 5'h00;
    endsequence

    property p_wake_fwd;
        s_periph_wake |=> (WAKE_CPU_OUT && WAKE_CLK_OUT);
    endproperty
    a_wake_fwd: assert property (p_wake_fwd)
        else $error("peripheral wake not forwarded");

endmodule

// File: tb/cpu_side_model.sv
// processor, interrupt controller and clock unit as seen from the line controller
`timescale 1ns/1ps
module cpu_side_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // requests from the controller
    input  wire logic [15:0] irq_in,
    input  wire logic        event_irq_in,
    input  wire logic        wake_cpu_in,
    input  wire logic        wake_clk_in,
    // observed state
    output logic      [15:0] pending_out,
    output logic             awake_out,
    output logic             ev_seen_out
);
    // ****************************************
    // pending latch and wake tracking
    // ****************************************
    // pending is sticky: the real core keeps a request until it is serviced
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pending_out <= 16'h0000;
            awake_out   <= 1'b0;
            ev_seen_out <= 1'b0;
        end else begin
            ev_seen_out <= ev_seen_out | event_irq_in;
            pending_out <= pending_out | irq_in;
            // wake counts only when both cpu and clock unit see it
            awake_out   <= awake_out | (wake_cpu_in & wake_clk_in);
        end
    end
endmodule

// File: tb/testbench.sv
// self-checking bench for the external line controller
`timescale 1ns/1ps
module testbench;
    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [15:0] line;
    logic [4:0]  pwake;
    logic [15:0] irq;
    logic        ev_irq;
    logic        wk_cpu;
    logic        wk_clk;
    logic [15:0] pending;
    logic        awake;
    logic        ev_seen;
    int          errors;
    int          n_compared;

    ext_line_controller dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .LINE_IN(line),
        .PERIPH_WAKE_IN(pwake), .LINE_IRQ_OUT(irq), .EVENT_WAKE_IRQ_OUT(ev_irq),
        .WAKE_CPU_OUT(wk_cpu), .WAKE_CLK_OUT(wk_clk));
    cpu_side_model cpu (.clk_in(clk), .rst_in(rst), .irq_in(irq), .event_irq_in(ev_irq),
        .wake_cpu_in(wk_cpu), .wake_clk_in(wk_clk), .pending_out(pending), .awake_out(awake),
        .ev_seen_out(ev_seen));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // clock, reset, watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        errors++;
        complete_run();
    end

    // ****************************************
    // tests
    // ****************************************
    // rows indexed by trigger type: request after a rise, after a fall
    localparam logic [7:0] EXP_RISE = 8'hFA;
    localparam logic [7:0] EXP_FALL = 8'hF5;
    initial begin
        errors = 0;
        n_compared = 0;
        rst = 1'b1; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
        line = 16'h0000; pwake = 5'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // reset values, refused and unaligned addresses
        rd_reg(8'h40, 32'h0);
        rd_reg(8'h50, 32'h0);
        rd_reg(8'h58, 32'h0);
        wr_reg(8'h40, 32'h0000_0001);
        rd_reg(8'h41, 32'h0);
        rd_reg(8'h80, 32'h0);
        rd_reg(8'h40, 32'h1);
        tick(1);
        chk("rdata idle", rdata, 32'h0);
        // every trigger type on line 0, the other fifteen masked off
        for (int t = 0; t < 8; t++) begin
            wr_reg(8'h00, 32'(t) << 28);
            wr_reg(8'h44, 32'h0000_FFFF);
            line[0] <= 1'b1;
            tick(8);
            chk("irq rise", 32'(irq), {31'h0, EXP_RISE[t]});
            rd_reg(8'h48, 32'h1);
            wr_reg(8'h44, 32'h0000_FFFF);
            line[0] <= 1'b0;
            tick(8);
            chk("irq fall", 32'(irq), {31'h0, EXP_FALL[t]});
            rd_reg(8'h48, 32'h0);
        end
        // software request, then masked
        wr_reg(8'h40, 32'h0000_0020);
        wr_reg(8'h4C, 32'h0000_0020);
        tick(3);
        chk("sw irq", 32'(irq), 32'h20);
        rd_reg(8'h4C, 32'h20);
        wr_reg(8'h40, 32'h0);
        tick(3);
        chk("sw masked", 32'(irq), 32'h0);
        wr_reg(8'h4C, 32'h0);
        // debounce, count ten on line 2 rising
        wr_reg(8'h40, 32'h0000_0004);
        wr_reg(8'h08, 32'hB000_000A);
        rd_reg(8'h08, 32'hB000_000A);
        wr_reg(8'h44, 32'h0000_FFFF);
        line[2] <= 1'b1;
        tick(5);
        line[2] <= 1'b0;
        tick(20);
        chk("short pulse", 32'(irq), 32'h0);
        line[2] <= 1'b1;
        tick(11);
        chk("db wait", 32'(irq), 32'h0);
        tick(2);
        chk("db irq", 32'(irq), 32'h4);
        rd_reg(8'h44, 32'h4);
        wr_reg(8'h40, 32'h0);
        // line wake on line 3, high active
        wr_reg(8'h50, 32'h8000_0008);
        line[3] <= 1'b1;
        tick(2);
        chk("wake sync", 32'(wk_cpu), 32'h0);
        tick(6);
        chk("wake cpu", 32'(wk_cpu), 32'h1);
        chk("wake clk", 32'(wk_clk), 32'h1);
        chk("ev irq", 32'(ev_irq), 32'h1);
        line[3] <= 1'b0;
        tick(8);
        chk("wake level", 32'(wk_cpu), 32'h0);
        chk("ev held", 32'(ev_irq), 32'h1);
        rd_reg(8'h58, 32'h8);
        wr_reg(8'h58, 32'h8);
        tick(2);
        chk("ev cleared", 32'(ev_irq), 32'h0);
        // low-active polarity, then interrupt enable off
        wr_reg(8'h54, 32'h8);
        tick(8);
        chk("wake pol", 32'(wk_cpu), 32'h1);
        rd_reg(8'h54, 32'h8);
        wr_reg(8'h50, 32'h0000_0008);
        tick(2);
        chk("ev off", 32'(ev_irq), 32'h0);
        wr_reg(8'h50, 32'h0);
        tick(4);
        // peripheral wake sources
        for (int i = 0; i < 5; i++) begin
            pwake[i] <= 1'b1;
            tick(3);
            chk("periph wake", 32'(wk_cpu & wk_clk), 32'h1);
            pwake[i] <= 1'b0;
            tick(3);
            chk("periph idle", 32'(wk_cpu), 32'h0);
        end
        chk("pending", 32'(pending), 32'h25);
        chk("awake", 32'(awake), 32'h1);
        chk("ev seen", 32'(ev_seen), 32'h1);
        complete_run();
    end
endmodule
